/* verilog/pgm_regs.svh */
`ifndef PGM_REGS_SVH
`define PGM_REGS_SVH
// Register byte offsets
`define PGM_CTRL1_OFS 12'h000
`define PGM_CTRL2_OFS 12'h004
`define PGM_FAULT_OFS 12'h008
`define PGM_TOP_OFS 12'h00C
`define PGM_STAT_OFS 12'h010
`define PGM_EVT_OFS 12'h014
// Control one fields: [3:0] rail monitor enables, [7:4] window selects
`define PGM_C1_EN_LSB 0
`define PGM_C1_WIN_LSB 4
`define PGM_C1_POL_BIT 8
`define PGM_C1_OD_BIT 9
`define PGM_C1_RST 10'h000
// Control two fields
`define PGM_C2_TWARN_BIT 0
`define PGM_C2_MODE_BIT 1
`define PGM_C2_GATE_BIT 2
// Top interrupt fields
`define PGM_TOP_OVP_BIT 0
`define PGM_TOP_TSD_BIT 1
// Timing
`define PGM_GATE_US 800
`define PGM_CLK_MHZ 50
`define PGM_GATE_CYC (`PGM_GATE_US * `PGM_CLK_MHZ)
`endif

/* verilog/pgm_pkg.sv */
package pgm_pkg;
   typedef enum logic [1:0]
   {
      PGM_LOAD = 2'b00,
      PGM_RUN = 2'b01,
      PGM_GATE = 2'b11,
      PGM_HOLD = 2'b10
   } pgm_state_e;
endpackage

/* verilog/pgm_monitor.sv */
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pgm_regs.svh"

// Behaviour
// R1: Each rail's validity can be individually selected to feed power-good.
// R2: A disabled regulator is masked from the power-good combination.
// R3: A select bit adds thermal warning as a power-good source.
// R4: Power-good is active only when all selected sources are valid.
// R5: Window bit 0 checks undervoltage only; 1 checks under and over.
// R6: Control bits choose pin polarity and push-pull or open-drain drive.
// R7: Polarity inverts only the pin, not status or interrupt.
// R8: Status bit reads 1 when the pin signals all voltages valid.
// R9: Mode bit defaults from strap; 0 gated, 1 continuous.
// R10: Power-good is asserted on leaving configuration load.
// R11: Gated mode holds power-good unchanged through an 800 us window.
// R12: After the window, gated mode deasserts if any output is bad.
// R13: Each detected fault sets its per-source fault bit.
// R14: Gated monitoring resumes only after the host clears the fault.
// R15: Write 1 clears a rail fault; overvoltage and shutdown clear via interrupts.
// R16: Continuous mode deasserts power-good when a monitored regulator is enabled.
// R17: Continuous mode follows live regulation status, including sequencing.
// R18: Fault bits stay latched until the host writes 1 to them.
// R19: Continuous mode deasserts power-good during a voltage transition.
// R20: Continuous mode reasserts on recovery unless fault gating is enabled.
// R21: With fault gating set, pending fault bits hold power-good inactive.
// R22: Shutdown or overvoltage disables all rails and drives both outputs low.
// R23: A set interrupt source pulls the low-active interrupt pin low.
// R24: Interrupt clear has no effect while the cause persists.
// R25: Gate window restarts at every enable and voltage change request.
module pgm_monitor #(
   parameter int NRAIL = 4,
   parameter int GATE_CYC = `PGM_GATE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mode_strap,
   input wire logic config_done,
   input wire logic [NRAIL-1:0] rail_enable_req,
   input wire logic [NRAIL-1:0] rail_uv,
   input wire logic [NRAIL-1:0] rail_ov,
   input wire logic [NRAIL-1:0] rail_ramping,
   input wire logic [NRAIL-1:0] rail_vset_req,
   input wire logic thermal_warning_status,
   input wire logic ovp_cond,
   input wire logic tsd_cond,
   input wire logic [1:0] gen_out_req,
   output logic [NRAIL-1:0] rail_enable,
   output logic general_output_one,
   output logic general_output_two,
   output logic power_good_output_o,
   output logic power_good_output_oe,
   output logic power_good_interrupt,
   output logic interrupt_pin_low_active_n
);

   localparam int CW = $clog2(GATE_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic awv;
      logic [11:0] awa;
      logic wv;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic rv;
      logic [31:0] rd;
      logic [NRAIL-1:0] men;
      logic [NRAIL-1:0] win;
      logic pol;
      logic od;
      logic twen;
      logic mode;
      logic fgate;
      logic [NRAIL-1:0] fault;
      logic ovp;
      logic tsd;
      logic pg;
      logic pg_prev;
      pgm_pkg::pgm_state_e st;
      logic [CW-1:0] cnt;
      logic [NRAIL-1:0] en_prev;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [NRAIL-1:0] uv1;
      logic [NRAIL-1:0] uv2;
      logic [NRAIL-1:0] ov1;
      logic [NRAIL-1:0] ov2;
   } pgm_state_s;

   pgm_state_s s_q;
   pgm_state_s s_d;
   logic [NRAIL-1:0] rail_bad;
   logic [NRAIL-1:0] act_en;
   logic all_ok;
   logic wr_go;
   logic trip;
   logic ovp_s;
   logic tsd_s;
   logic tw_s;
   logic cfg_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronised condition inputs
   assign ovp_s = s_q.sync2[0];
   assign tsd_s = s_q.sync2[1];
   assign tw_s = s_q.sync2[2];
   assign cfg_s = s_q.sync2[3];

   // Trip on shutdown, overvoltage or their pending interrupt
   assign trip = s_q.ovp | s_q.tsd | ovp_s | tsd_s;
   assign act_en = trip ? '0 : rail_enable_req; // [R22]

   // Per-rail badness with window select and masking
   genvar g;
   generate
      for (g = 0; g < NRAIL; g++)
      begin : g_rail
         assign rail_bad[g] = s_q.men[g] & act_en[g] // [R1] [R2]
            & (s_q.uv2[g] | (s_q.win[g] & s_q.ov2[g]) | rail_ramping[g]); // [R5] [R19]
      end
   endgenerate

   // Combined validity of all selected sources
   assign all_ok = ~(|rail_bad) & ~(s_q.twen & tw_s) & ~s_q.ovp & ~s_q.tsd; // [R3] [R4]
   assign wr_go = s_q.awv & s_q.wv & ~s_q.bv;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = {config_done, thermal_warning_status, tsd_cond, ovp_cond};
      s_d.sync2 = s_q.sync1;
      s_d.uv1 = rail_uv;
      s_d.uv2 = s_q.uv1;
      s_d.ov1 = rail_ov;
      s_d.ov2 = s_q.ov1;
      s_d.en_prev = act_en;
      s_d.pg_prev = s_q.pg;
      // Bus channels
      if (s_axi_awvalid && !s_q.awv)
      begin
         s_d.awv = 1'b1;
         s_d.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.wv)
      begin
         s_d.wv = 1'b1;
         s_d.wd = s_axi_wdata;
         s_d.ws = s_axi_wstrb;
      end
      if (s_q.bv && s_axi_bready)
         s_d.bv = 1'b0;
      if (s_q.rv && s_axi_rready)
         s_d.rv = 1'b0;
      // Hardware fault setting
      if (rail_bad != '0 && s_q.st != pgm_pkg::PGM_GATE && s_q.st != pgm_pkg::PGM_LOAD)
         s_d.fault = s_q.fault | rail_bad; // [R13]
      // Register writes; clears lose to a same-cycle set
      if (wr_go)
      begin
         s_d.awv = 1'b0;
         s_d.wv = 1'b0;
         s_d.bv = 1'b1;
         if (s_q.ws[0] || s_q.ws[1])
         begin
            case (s_q.awa)
               `PGM_CTRL1_OFS:
               begin
                  s_d.men = s_q.wd[`PGM_C1_EN_LSB +: NRAIL];
                  s_d.win = s_q.wd[`PGM_C1_WIN_LSB +: NRAIL];
                  s_d.pol = s_q.wd[`PGM_C1_POL_BIT]; // [R6]
                  s_d.od = s_q.wd[`PGM_C1_OD_BIT];
               end
               `PGM_CTRL2_OFS:
               begin
                  s_d.twen = s_q.wd[`PGM_C2_TWARN_BIT];
                  s_d.mode = s_q.wd[`PGM_C2_MODE_BIT]; // [R9]
                  s_d.fgate = s_q.wd[`PGM_C2_GATE_BIT];
               end
               `PGM_FAULT_OFS: s_d.fault = (s_q.fault & ~s_q.wd[NRAIL-1:0]) | rail_bad; // [R15] [R18]
               `PGM_TOP_OFS:
               begin
                  if (s_q.wd[`PGM_TOP_OVP_BIT] && !ovp_s)
                     s_d.ovp = 1'b0; // [R24]
                  if (s_q.wd[`PGM_TOP_TSD_BIT] && !tsd_s)
                     s_d.tsd = 1'b0; // [R24]
               end
               default: ;
            endcase
         end
      end
      if (ovp_s)
         s_d.ovp = 1'b1;
      if (tsd_s)
         s_d.tsd = 1'b1;
      // Read data
      if (s_axi_arvalid && !s_q.rv)
      begin
         s_d.rv = 1'b1;
         case (s_axi_araddr)
            `PGM_CTRL1_OFS: s_d.rd = {22'h00_0000, s_q.od, s_q.pol,
               s_q.win, s_q.men};
            `PGM_CTRL2_OFS: s_d.rd = {29'h0000_0000, s_q.fgate, s_q.mode, s_q.twen};
            `PGM_FAULT_OFS: s_d.rd = {{(32-NRAIL){1'b0}}, s_q.fault};
            `PGM_TOP_OFS: s_d.rd = {30'h0000_0000, s_q.tsd, s_q.ovp};
            `PGM_STAT_OFS: s_d.rd = {31'h0000_0000, s_q.pg}; // [R8]
            default: s_d.rd = 32'h0000_0000;
         endcase
      end
      // Power-good sequencing
      case (s_q.st)
         pgm_pkg::PGM_LOAD:
         begin
            s_d.mode = mode_strap;
            if (cfg_s)
            begin
               s_d.pg = 1'b1; // [R10]
               s_d.st = pgm_pkg::PGM_RUN;
            end
         end
         pgm_pkg::PGM_RUN:
         begin
            if (s_q.mode)
            begin
               // Live tracking, newly enabled rails start inactive
               s_d.pg = all_ok & ~(|(act_en & ~s_q.en_prev & s_q.men)) // [R16] [R17] [R20]
                  & ~(s_q.fgate & (|s_q.fault)); // [R21]
            end
            else if ((act_en & ~s_q.en_prev) != '0 || rail_vset_req != '0)
            begin
               s_d.cnt = CW'(GATE_CYC - 1); // [R25]
               s_d.st = pgm_pkg::PGM_GATE;
            end
            else if (!all_ok)
            begin
               s_d.pg = 1'b0; // [R12]
               s_d.st = pgm_pkg::PGM_HOLD;
            end
         end
         pgm_pkg::PGM_GATE:
         begin
            if ((act_en & ~s_q.en_prev) != '0 || rail_vset_req != '0)
               s_d.cnt = CW'(GATE_CYC - 1); // [R25]
            else if (s_q.cnt == '0)
               s_d.st = pgm_pkg::PGM_RUN;
            else
               s_d.cnt = s_q.cnt - CW'(1); // [R11]
            if (s_q.mode)
               s_d.st = pgm_pkg::PGM_RUN;
         end
         pgm_pkg::PGM_HOLD:
         begin
            // Stays inactive until every fault is cleared and all sources are valid, or until continuous mode is selected
            if (s_q.mode || (s_q.fault == '0 && !s_q.ovp && !s_q.tsd && all_ok))
            begin
               s_d.pg = all_ok; // [R14]
               s_d.st = pgm_pkg::PGM_RUN;
            end
         end
         default: s_d.st = pgm_pkg::PGM_LOAD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.st <= pgm_pkg::PGM_LOAD;
         s_q.pg <= 1'b1;
         s_q.pg_prev <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = ~s_q.awv;
   assign s_axi_wready = ~s_q.wv;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = 2'b00;
   assign s_axi_arready = ~s_q.rv;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rd;
   assign s_axi_rresp = 2'b00;
   assign rail_enable = act_en;
   assign general_output_one = gen_out_req[0] & ~trip; // [R22]
   assign general_output_two = gen_out_req[1] & ~trip;
   // Pin level after polarity, open-drain drives only low
   assign power_good_output_o = s_q.pg ^ s_q.pol; // [R7]
   assign power_good_output_oe = ~s_q.od | ~power_good_output_o;
   assign power_good_interrupt = s_q.pg_prev & ~s_q.pg;
   assign interrupt_pin_low_active_n = ~(s_q.ovp | s_q.tsd); // [R23]

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_trip_off;
      @(posedge aclk) disable iff (!aresetn)
      trip |-> (rail_enable == '0) && !general_output_one && !general_output_two;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("Outputs live during trip"); // [R22]

   property p_pin_pol;
      @(posedge aclk) disable iff (!aresetn)
      power_good_output_o == (s_q.pg ^ s_q.pol);
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("Pin polarity wrong"); // [R7]

   property p_int_pin;
      @(posedge aclk) disable iff (!aresetn)
      ovp_s || tsd_s |=> !interrupt_pin_low_active_n;
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("Interrupt pin not low"); // [R23]

   property p_fault_hold;
      @(posedge aclk) disable iff (!aresetn)
      (s_q.fault != '0) && !wr_go |=> (s_q.fault & $past(s_q.fault)) == $past(s_q.fault);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("Fault bit lost"); // [R18]

   property p_fgate;
      @(posedge aclk) disable iff (!aresetn)
      s_q.mode && s_q.fgate && (s_q.fault != '0) && s_q.st == pgm_pkg::PGM_RUN |=> !s_q.pg;
   endproperty
   a_fgate: assert property (p_fgate) else $error("Fault gating ignored"); // [R21]

   property p_gate_hold;
      @(posedge aclk) disable iff (!aresetn)
      s_q.st == pgm_pkg::PGM_GATE && !s_q.mode |=> $stable(s_q.pg);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("Power-good moved in window"); // [R11]

   property p_cont_bad;
      @(posedge aclk) disable iff (!aresetn)
      s_q.mode && s_q.st == pgm_pkg::PGM_RUN && !all_ok |=> !s_q.pg;
   endproperty
   a_cont_bad: assert property (p_cont_bad) else $error("Power-good active while bad"); // [R17]

   property p_tsd_clr;
      @(posedge aclk) disable iff (!aresetn)
      tsd_s |=> s_q.tsd;
   endproperty
   a_tsd_clr: assert property (p_tsd_clr) else $error("Shutdown flag cleared early"); // [R24]

endmodule

/* bench/pgm_host_model.sv */
`timescale 1ns/100ps
// Host reset input seen through the power-good pin
module pgm_host_model
(
   input wire logic aclk,
   input wire logic pg_pin_o,
   input wire logic pg_pin_oe,
   output logic pin_level,
   output logic host_run_q
);
   // Released open-drain pin rests at the board pull-up
   assign pin_level = pg_pin_oe ? pg_pin_o : 1'b1;
   // Host leaves reset once the pin has been seen high
   always_ff @(posedge aclk)
   begin
      host_run_q <= pin_level;
   end
endmodule

/* bench/power_good_monitor_tb_top.sv */
`timescale 1ns/100ps
`include "pgm_regs.svh"
module power_good_monitor_tb_top;
   typedef struct {logic [31:0] c1; logic [31:0] c2; logic [3:0] en; logic [3:0] uv;
      logic [3:0] ov; logic [3:0] rp; logic tw; logic pg;} pgm_row_s;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, rail_enable_req, rail_uv, rail_ov, rail_ramping;
   logic [3:0] rail_vset_req, rail_enable;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, gen_out_req;
   logic mode_strap, config_done, thermal_warning_status, ovp_cond, tsd_cond;
   logic general_output_one, general_output_two, power_good_output_o, power_good_output_oe;
   logic power_good_interrupt, interrupt_pin_low_active_n, pin_level, host_run;
   int error_cnt = 0;
   int samples_checked = 0;
   int pgi_cnt = 0;
   pgm_row_s rows [9];

   pgm_monitor #(.GATE_CYC(20)) u_dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_strap, .config_done,
      .rail_enable_req, .rail_uv, .rail_ov, .rail_ramping, .rail_vset_req,
      .thermal_warning_status, .ovp_cond, .tsd_cond, .gen_out_req, .rail_enable,
      .general_output_one, .general_output_two, .power_good_output_o,
      .power_good_output_oe, .power_good_interrupt, .interrupt_pin_low_active_n
   );
   pgm_host_model u_host
   (
      .aclk, .pg_pin_o(power_good_output_o), .pg_pin_oe(power_good_output_oe),
      .pin_level, .host_run_q(host_run)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock and rising-edge count of the power-good interrupt pulse
   always #10 aclk = ~aclk;
   always @(posedge aclk)
      if (power_good_interrupt === 1'b1) pgi_cnt++;

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task test_done();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1)
         begin
            s_axi_awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && s_axi_wready === 1'b1)
         begin
            s_axi_wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [11:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Status word and pin level against the expected power-good state
   task chk_pg(input logic pg, input logic pol);
      axi_rd(`PGM_STAT_OFS, rd);
      chk(rd, {31'h0000_0000, pg});
      chk({31'h0000_0000, pin_level}, {31'h0000_0000, pg ^ pol});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rows = '{
         '{32'h0000_000F, 32'h0000_0002, 4'hF, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1},
         '{32'h0000_000F, 32'h0000_0002, 4'hF, 4'h1, 4'h0, 4'h0, 1'b0, 1'b0},
         '{32'h0000_000E, 32'h0000_0002, 4'hF, 4'h1, 4'h0, 4'h0, 1'b0, 1'b1},
         '{32'h0000_000F, 32'h0000_0002, 4'hE, 4'h1, 4'h0, 4'h0, 1'b0, 1'b1},
         '{32'h0000_000F, 32'h0000_0002, 4'hF, 4'h0, 4'h2, 4'h0, 1'b0, 1'b1},
         '{32'h0000_002F, 32'h0000_0002, 4'hF, 4'h0, 4'h2, 4'h0, 1'b0, 1'b0},
         '{32'h0000_000F, 32'h0000_0002, 4'hF, 4'h0, 4'h0, 4'h4, 1'b0, 1'b0},
         '{32'h0000_000F, 32'h0000_0002, 4'hF, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1},
         '{32'h0000_000F, 32'h0000_0003, 4'hF, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0}};
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      {mode_strap, config_done, thermal_warning_status, ovp_cond, tsd_cond} = 5'h10;
      {rail_enable_req, rail_uv, rail_ov, rail_ramping, rail_vset_req} = 20'hF_0000;
      gen_out_req = 2'b11;
      cyc(10);
      aresetn <= 1'b1;
      cyc(2);
      config_done <= 1'b1;
      cyc(6);
      chk_pg(1'b1, 1'b0);
      axi_rd(`PGM_CTRL2_OFS, rd);
      chk(rd, 32'h0000_0002);
      axi_rd(12'h0FC, rd);
      chk(rd, 32'h0000_0000);
      foreach (rows[i])
      begin
         axi_wr(`PGM_CTRL1_OFS, rows[i].c1);
         axi_wr(`PGM_CTRL2_OFS, rows[i].c2);
         rail_enable_req <= rows[i].en;
         rail_uv <= rows[i].uv;
         rail_ov <= rows[i].ov;
         rail_ramping <= rows[i].rp;
         thermal_warning_status <= rows[i].tw;
         cyc(8);
         chk_pg(rows[i].pg, 1'b0);
         {rail_enable_req, rail_uv, rail_ov, rail_ramping, thermal_warning_status} <= 17'h1E000;
         cyc(8);
         axi_wr(`PGM_FAULT_OFS, 32'h0000_000F);
      end
      // Pin polarity and drive type
      axi_wr(`PGM_CTRL1_OFS, 32'h0000_010F);
      chk_pg(1'b1, 1'b1);
      axi_wr(`PGM_CTRL1_OFS, 32'h0000_020F);
      chk_pg(1'b1, 1'b0);
      chk({31'h0000_0000, power_good_output_oe}, 32'h0000_0000);
      axi_wr(`PGM_CTRL1_OFS, 32'h0000_000F);
      // Latched faults holding power-good down
      axi_wr(`PGM_CTRL2_OFS, 32'h0000_0006);
      rail_uv <= 4'h8;
      cyc(8);
      rail_uv <= 4'h0;
      cyc(8);
      chk_pg(1'b0, 1'b0);
      axi_rd(`PGM_FAULT_OFS, rd);
      chk(rd, 32'h0000_0008);
      axi_wr(`PGM_FAULT_OFS, 32'h0000_0008);
      axi_rd(`PGM_FAULT_OFS, rd);
      chk(rd, 32'h0000_0000);
      chk_pg(1'b1, 1'b0);
      axi_wr(`PGM_CTRL2_OFS, 32'h0000_0002);
      // Input overvoltage, then thermal shutdown
      for (int k = 0; k < 2; k++)
      begin
         {tsd_cond, ovp_cond} <= 2'b01 << k;
         cyc(8);
         chk({28'h000_0000, rail_enable}, 32'h0000_0000);
         chk({30'h0000_0000, general_output_two, general_output_one}, 32'h0000_0000);
         chk({31'h0000_0000, interrupt_pin_low_active_n}, 32'h0000_0000);
         chk_pg(1'b0, 1'b0);
         axi_wr(`PGM_TOP_OFS, 32'h0000_0003);
         axi_rd(`PGM_TOP_OFS, rd);
         chk(rd, {30'h0000_0000, 2'b01 << k});
         {tsd_cond, ovp_cond} <= 2'b00;
         cyc(6);
         axi_wr(`PGM_TOP_OFS, 32'h0000_0003);
         axi_wr(`PGM_FAULT_OFS, 32'h0000_000F);
         cyc(6);
         chk({31'h0000_0000, interrupt_pin_low_active_n}, 32'h0000_0001);
         chk_pg(1'b1, 1'b0);
      end
      // Gated window after a voltage change request
      axi_wr(`PGM_CTRL2_OFS, 32'h0000_0000);
      rail_vset_req <= 4'h1;
      cyc(1);
      rail_vset_req <= 4'h0;
      rail_uv <= 4'h1;
      cyc(10);
      chk({31'h0000_0000, pin_level}, 32'h0000_0001);
      // A second request inside the window restarts it
      rail_vset_req <= 4'h1;
      cyc(1);
      rail_vset_req <= 4'h0;
      cyc(14);
      chk({31'h0000_0000, pin_level}, 32'h0000_0001);
      cyc(16);
      chk_pg(1'b0, 1'b0);
      rail_uv <= 4'h0;
      cyc(8);
      chk_pg(1'b0, 1'b0);
      axi_rd(`PGM_FAULT_OFS, rd);
      chk(rd, 32'h0000_0001);
      axi_wr(`PGM_FAULT_OFS, 32'h0000_0001);
      cyc(8);
      chk_pg(1'b1, 1'b0);
      // Mid-run reset from an inactive state, strap now selecting gated mode
      rail_uv <= 4'h1;
      cyc(8);
      chk_pg(1'b0, 1'b0);
      aresetn <= 1'b0;
      mode_strap <= 1'b0;
      config_done <= 1'b0;
      cyc(10);
      aresetn <= 1'b1;
      cyc(2);
      chk({31'h0000_0000, pin_level}, 32'h0000_0001);
      config_done <= 1'b1;
      cyc(6);
      mode_strap <= 1'b1;
      cyc(2);
      chk_pg(1'b1, 1'b0);
      chk({31'h0000_0000, host_run}, 32'h0000_0001);
      axi_rd(`PGM_CTRL2_OFS, rd);
      chk(rd, 32'h0000_0000);
      chk({31'h0000_0000, pgi_cnt > 0}, 32'h0000_0001);
      test_done();
   end
endmodule
